/* sfi_ctrl.sv */
`timescale 1ns/1ps

module sfi_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic d,
  output logic q
);
  logic s1_ff, s2_ff, s3_ff, filt_ff;
  logic nxt_filt;
  always_comb begin
    nxt_filt = (s2_ff == s3_ff) ? s3_ff : filt_ff;
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_ff <= RST_VAL;
      s2_ff <= RST_VAL;
      s3_ff <= RST_VAL;
      filt_ff <= RST_VAL;
    end else begin
      s1_ff <= d;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      filt_ff <= nxt_filt;
    end
  end
  assign q = filt_ff;
endmodule

module sfi_ctrl #(
  parameter int TX_DEPTH = 16,
  parameter int RX_DEPTH = 32
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic link_clk,
  input wire logic ctl_psel,
  input wire logic ctl_penable,
  input wire logic ctl_pwrite,
  input wire logic [7:0] ctl_paddr,
  input wire logic [31:0] ctl_pwdata,
  output logic [31:0] ctl_prdata,
  output logic ctl_pready,
  input wire logic fifo_psel,
  input wire logic fifo_penable,
  input wire logic fifo_pwrite,
  input wire logic [7:0] fifo_paddr,
  input wire logic [31:0] fifo_pwdata,
  output logic [31:0] fifo_prdata,
  output logic fifo_pready,
  output logic irq,
  output logic sck,
  output logic ss_b,
  output logic [3:0] data_out,
  output logic [3:0] data_oe,
  input wire logic [3:0] data_in
);
  localparam int TPW = $clog2(TX_DEPTH);
  localparam int TCW = $clog2(TX_DEPTH + 1);
  localparam int RPW = $clog2(RX_DEPTH);
  localparam int RCW = $clog2(RX_DEPTH + 1);

  if (TX_DEPTH < 2 || TX_DEPTH > 16 || (TX_DEPTH & (TX_DEPTH - 1)) != 0) begin : g_bad_tx
    $error("TX_DEPTH must be a power of two from 2 to 16");
  end
  if (RX_DEPTH < 2 || RX_DEPTH > 32 || (RX_DEPTH & (RX_DEPTH - 1)) != 0) begin : g_bad_rx
    $error("RX_DEPTH must be a power of two from 2 to 32");
  end

  function automatic logic [3:0] out_bits(input logic [7:0] sh, input logic [1:0] w);
    case (w)
      sfi_pkg::SFI_W_DUAL: out_bits = {2'h0, sh[7:6]};
      sfi_pkg::SFI_W_QUAD: out_bits = sh[7:4];
      default: out_bits = {3'h0, sh[7]};
    endcase
  endfunction

  function automatic logic [3:0] oe_bits(input logic [1:0] w, input logic rd);
    case (w)
      sfi_pkg::SFI_W_DUAL: oe_bits = rd ? 4'h0 : 4'h3;
      sfi_pkg::SFI_W_QUAD: oe_bits = rd ? 4'h0 : 4'hF;
      default: oe_bits = 4'h1;
    endcase
  endfunction

  function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic [1:0] w,
                                          input logic [3:0] din);
    case (w)
      sfi_pkg::SFI_W_DUAL: shift_in = {sh[5:0], din[1:0]};
      sfi_pkg::SFI_W_QUAD: shift_in = {sh[3:0], din[3:0]};
      default: shift_in = {sh[6:0], din[1]};
    endcase
  endfunction

  function automatic logic [2:0] last_step(input logic [1:0] w);
    case (w)
      sfi_pkg::SFI_W_DUAL: last_step = 3'h3;
      sfi_pkg::SFI_W_QUAD: last_step = 3'h1;
      default: last_step = 3'h7;
    endcase
  endfunction

  // core domain
  logic [31:0] tx_mem [TX_DEPTH];
  logic [7:0] rx_mem [RX_DEPTH];
  logic [TPW-1:0] tx_wp_ff, tx_rp_ff, nxt_tx_wp, nxt_tx_rp;
  logic [RPW-1:0] rx_wp_ff, rx_rp_ff, nxt_rx_wp, nxt_rx_rp;
  logic [TCW-1:0] tx_cnt_ff, nxt_tx_cnt;
  logic [RCW-1:0] rx_cnt_ff, nxt_rx_cnt;
  logic [5:0] flags_ff, nxt_flags, en_ff, nxt_en, cond;
  logic [3:0] tlvl_ff, nxt_tlvl;
  logic [4:0] rlvl_ff, nxt_rlvl;
  logic [31:0] ctl_rd_ff, nxt_ctl_rd, fifo_rd_ff, nxt_fifo_rd, xfer_word_ff, nxt_xfer_word;
  logic ctl_rdy_ff, fifo_rdy_ff, irq_ff, nxt_irq, req_tgl_ff, nxt_req_tgl;
  logic ack_seen_ff, nxt_ack_seen;
  sfi_pkg::sfi_core_st_t cst_ff, nxt_cst;
  logic ack_filt, ss_b_filt, ack_evt, ss_on;
  logic ctl_wr, fifo_wr, tx_push, tx_pop, rx_push, rx_pop, tx_empty, rx_empty, rx_full;
  logic [7:0] rsp_ff;
  logic ack_tgl_ff, ss_b_ff;

  sfi_sync u_ack_sync (.clk(core_clk), .rst_b(rst_b), .d(ack_tgl_ff), .q(ack_filt));
  // starts at the idle select level so no stall is seen right after reset
  sfi_sync #(.RST_VAL(1'b1)) u_ss_sync (.clk(core_clk), .rst_b(rst_b), .d(ss_b_ff),
    .q(ss_b_filt));

  always_comb begin
    ss_on = !ss_b_filt;
    ack_evt = ack_filt != ack_seen_ff;
    tx_empty = tx_cnt_ff == '0;
    rx_empty = rx_cnt_ff == '0;
    rx_full = rx_cnt_ff == RCW'(RX_DEPTH);
    ctl_wr = ctl_psel && ctl_penable && ctl_pwrite && ctl_rdy_ff;
    fifo_wr = fifo_psel && fifo_penable && fifo_pwrite && fifo_rdy_ff;
    tx_push = fifo_wr && fifo_paddr == sfi_pkg::TX_PORT_OFS && tx_cnt_ff != TCW'(TX_DEPTH);
    rx_pop = fifo_psel && !fifo_penable && !fifo_pwrite &&
             fifo_paddr == sfi_pkg::RX_PORT_OFS && !rx_empty;
    // a new word is launched only when its result can be stored
    tx_pop = cst_ff == sfi_pkg::C_IDLE && !tx_empty && !rx_full;
    rx_push = cst_ff == sfi_pkg::C_WAIT && ack_evt && xfer_word_ff[sfi_pkg::XW_READ_BIT];
    // receive used count or transmit free count must exceed the level
    cond[sfi_pkg::FL_RX_AF] = rx_cnt_ff > RCW'(rlvl_ff);
    cond[sfi_pkg::FL_TX_AE] = (TCW'(TX_DEPTH) - tx_cnt_ff) > TCW'(tlvl_ff);
    cond[sfi_pkg::FL_RDONE] = !rx_empty && !ss_on;
    cond[sfi_pkg::FL_TRDY] = tx_empty && !ss_on;
    cond[sfi_pkg::FL_RSTALL] = rx_full && ss_on;
    cond[sfi_pkg::FL_TSTALL] = tx_empty && ss_on;
  end

  always_comb begin
    nxt_tx_wp = tx_push ? tx_wp_ff + TPW'(1) : tx_wp_ff;
    nxt_tx_rp = tx_pop ? tx_rp_ff + TPW'(1) : tx_rp_ff;
    nxt_rx_wp = rx_push ? rx_wp_ff + RPW'(1) : rx_wp_ff;
    nxt_rx_rp = rx_pop ? rx_rp_ff + RPW'(1) : rx_rp_ff;
    nxt_tx_cnt = tx_cnt_ff + TCW'(tx_push) - TCW'(tx_pop);
    nxt_rx_cnt = rx_cnt_ff + RCW'(rx_push) - RCW'(rx_pop);
    nxt_cst = cst_ff;
    nxt_xfer_word = xfer_word_ff;
    nxt_req_tgl = req_tgl_ff;
    nxt_ack_seen = ack_evt ? ack_filt : ack_seen_ff;
    unique case (cst_ff)
      sfi_pkg::C_IDLE: begin
        if (tx_pop) begin
          nxt_xfer_word = tx_mem[tx_rp_ff];
          nxt_req_tgl = !req_tgl_ff;
          nxt_cst = sfi_pkg::C_WAIT;
        end
      end
      sfi_pkg::C_WAIT: begin
        if (ack_evt) begin
          nxt_cst = sfi_pkg::C_IDLE;
        end
      end
    endcase
    // set wins over a same-cycle clear
    nxt_flags = flags_ff | cond;
    if (ctl_wr && ctl_paddr == sfi_pkg::INT_FL_OFS) begin
      nxt_flags = (flags_ff & ~ctl_pwdata[5:0]) | cond;
    end
    nxt_en = en_ff;
    nxt_tlvl = tlvl_ff;
    nxt_rlvl = rlvl_ff;
    if (ctl_wr && ctl_paddr == sfi_pkg::INT_EN_OFS) begin
      nxt_en = ctl_pwdata[5:0];
    end
    if (ctl_wr && ctl_paddr == sfi_pkg::FIFO_CTRL_OFS) begin
      nxt_tlvl = ctl_pwdata[sfi_pkg::TLVL_LSB +: sfi_pkg::TLVL_W];
      nxt_rlvl = ctl_pwdata[sfi_pkg::RLVL_LSB +: sfi_pkg::RLVL_W];
    end
    nxt_irq = |(flags_ff & en_ff);
    nxt_ctl_rd = ctl_rd_ff;
    if (ctl_psel && !ctl_penable) begin
      unique case (ctl_paddr)
        sfi_pkg::INT_FL_OFS: nxt_ctl_rd = {26'h000_0000, flags_ff};
        sfi_pkg::INT_EN_OFS: nxt_ctl_rd = {26'h000_0000, en_ff};
        sfi_pkg::FIFO_CTRL_OFS: nxt_ctl_rd = (32'(rx_cnt_ff) << sfi_pkg::RCNT_LSB)
            | (32'(rlvl_ff) << sfi_pkg::RLVL_LSB) | (32'(tx_cnt_ff) << sfi_pkg::TCNT_LSB)
            | (32'(tlvl_ff) << sfi_pkg::TLVL_LSB);
        default: nxt_ctl_rd = 32'h0000_0000;
      endcase
    end
    nxt_fifo_rd = fifo_rd_ff;
    if (fifo_psel && !fifo_penable) begin
      nxt_fifo_rd = rx_pop ? {24'h00_0000, rx_mem[rx_rp_ff]} : 32'h0000_0000;
    end
  end

  always_ff @(posedge core_clk) begin
    if (tx_push) begin
      tx_mem[tx_wp_ff] <= fifo_pwdata;
    end
    if (rx_push) begin
      rx_mem[rx_wp_ff] <= rsp_ff;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_wp_ff <= '0;
      tx_rp_ff <= '0;
      rx_wp_ff <= '0;
      rx_rp_ff <= '0;
      tx_cnt_ff <= '0;
      rx_cnt_ff <= '0;
      flags_ff <= sfi_pkg::INT_FL_RST;
      en_ff <= sfi_pkg::INT_EN_RST;
      tlvl_ff <= sfi_pkg::TLVL_RST;
      rlvl_ff <= sfi_pkg::RLVL_RST;
      ctl_rd_ff <= 32'h0000_0000;
      fifo_rd_ff <= 32'h0000_0000;
      ctl_rdy_ff <= 1'b0;
      fifo_rdy_ff <= 1'b0;
      irq_ff <= 1'b0;
      xfer_word_ff <= 32'h0000_0000;
      req_tgl_ff <= 1'b0;
      ack_seen_ff <= 1'b0;
      cst_ff <= sfi_pkg::C_IDLE;
    end else begin
      tx_wp_ff <= nxt_tx_wp;
      tx_rp_ff <= nxt_tx_rp;
      rx_wp_ff <= nxt_rx_wp;
      rx_rp_ff <= nxt_rx_rp;
      tx_cnt_ff <= nxt_tx_cnt;
      rx_cnt_ff <= nxt_rx_cnt;
      flags_ff <= nxt_flags;
      en_ff <= nxt_en;
      tlvl_ff <= nxt_tlvl;
      rlvl_ff <= nxt_rlvl;
      ctl_rd_ff <= nxt_ctl_rd;
      fifo_rd_ff <= nxt_fifo_rd;
      ctl_rdy_ff <= ctl_psel && !ctl_penable;
      fifo_rdy_ff <= fifo_psel && !fifo_penable;
      irq_ff <= nxt_irq;
      xfer_word_ff <= nxt_xfer_word;
      req_tgl_ff <= nxt_req_tgl;
      ack_seen_ff <= nxt_ack_seen;
      cst_ff <= nxt_cst;
    end
  end

  assign ctl_prdata = ctl_rd_ff;
  assign ctl_pready = ctl_rdy_ff;
  assign fifo_prdata = fifo_rd_ff;
  assign fifo_pready = fifo_rdy_ff;
  assign irq = irq_ff;

  // assertions start one edge after reset lets go
  logic chk_on_ff;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      chk_on_ff <= 1'b0;
    end else begin
      chk_on_ff <= 1'b1;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!chk_on_ff);
  a_rx_af_set: assert property (cond[sfi_pkg::FL_RX_AF] |=> flags_ff[5])
    else $error("almost-full flag missed");
  a_tx_ae_set: assert property ((TCW'(TX_DEPTH) - tx_cnt_ff) > TCW'(tlvl_ff) |=> flags_ff[4])
    else $error("almost-empty flag missed");
  a_rdone_set: assert property (!rx_empty && ss_b_filt |=> flags_ff[3])
    else $error("results-done flag missed");
  a_trdy_set: assert property (tx_empty && ss_b_filt |=> flags_ff[2])
    else $error("transaction-ready flag missed");
  a_rstall_set: assert property (rx_cnt_ff == RCW'(RX_DEPTH) && !ss_b_filt |=> flags_ff[1])
    else $error("results-stalled flag missed");
  a_tstall_set: assert property (tx_cnt_ff == '0 && !ss_b_filt |=> flags_ff[0])
    else $error("transaction-stalled flag missed");
  a_irq_mask: assert property (##1 irq_ff == |($past(flags_ff) & $past(en_ff)))
    else $error("interrupt does not follow masked flags");
  a_flag_w1c: assert property (ctl_wr && ctl_paddr == sfi_pkg::INT_FL_OFS && ctl_pwdata[2]
      && !cond[2] |=> !flags_ff[2])
    else $error("flag not cleared by write of one");
  a_tx_push_cnt: assert property (tx_push && !tx_pop |=> tx_cnt_ff == $past(tx_cnt_ff) + 1)
    else $error("transmit write not counted");
  a_rx_pop_cnt: assert property (rx_pop && !rx_push |=> rx_cnt_ff == $past(rx_cnt_ff) - 1)
    else $error("receive read did not pop");
  a_depth_caps: assert property (tx_cnt_ff <= TCW'(TX_DEPTH) && rx_cnt_ff <= RCW'(RX_DEPTH))
    else $error("fifo count beyond depth");

  // link domain
  sfi_pkg::sfi_link_st_t lst_ff, nxt_lst;
  logic [7:0] sh_ff, nxt_sh, nxt_rsp;
  logic [2:0] step_ff, nxt_step;
  logic [1:0] wid_ff, nxt_wid;
  logic rd_ff, nxt_rd, end_ff, nxt_end, sck_ff, nxt_sck, nxt_ss_b, nxt_ack_tgl;
  logic req_seen_ff, nxt_req_seen, req_filt;
  logic [3:0] dout_ff, nxt_dout, doe_ff, nxt_doe;

  sfi_sync u_req_sync (.clk(link_clk), .rst_b(rst_b), .d(req_tgl_ff), .q(req_filt));

  always_comb begin
    nxt_lst = lst_ff;
    nxt_sh = sh_ff;
    nxt_step = step_ff;
    nxt_wid = wid_ff;
    nxt_rd = rd_ff;
    nxt_end = end_ff;
    nxt_sck = sck_ff;
    nxt_ss_b = ss_b_ff;
    nxt_ack_tgl = ack_tgl_ff;
    nxt_rsp = rsp_ff;
    nxt_req_seen = req_seen_ff;
    nxt_dout = dout_ff;
    nxt_doe = doe_ff;
    unique case (lst_ff)
      sfi_pkg::L_IDLE: begin
        if (req_filt != req_seen_ff) begin
          // word is held still by the core until the ack toggles back
          nxt_req_seen = req_filt;
          nxt_sh = xfer_word_ff[sfi_pkg::XW_DATA_LSB +: 8];
          nxt_wid = xfer_word_ff[sfi_pkg::XW_WIDTH_LSB +: 2];
          nxt_rd = xfer_word_ff[sfi_pkg::XW_READ_BIT];
          nxt_end = xfer_word_ff[sfi_pkg::XW_END_BIT];
          nxt_step = last_step(nxt_wid);
          nxt_dout = out_bits(nxt_sh, nxt_wid);
          nxt_doe = oe_bits(nxt_wid, nxt_rd);
          nxt_ss_b = 1'b0;
          nxt_lst = sfi_pkg::L_SHIFT;
        end
      end
      sfi_pkg::L_SHIFT: begin
        nxt_sck = !sck_ff;
        if (!sck_ff) begin
          nxt_sh = shift_in(sh_ff, wid_ff, data_in);
        end else if (step_ff == 3'h0) begin
          nxt_lst = sfi_pkg::L_DONE;
        end else begin
          nxt_step = step_ff - 3'h1;
          nxt_dout = out_bits(sh_ff, wid_ff);
        end
      end
      sfi_pkg::L_DONE: begin
        nxt_rsp = sh_ff;
        nxt_ack_tgl = !ack_tgl_ff;
        if (end_ff) begin
          nxt_ss_b = 1'b1;
          nxt_doe = 4'h0;
        end
        nxt_lst = sfi_pkg::L_IDLE;
      end
      default: nxt_lst = sfi_pkg::L_IDLE;
    endcase
  end

  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      lst_ff <= sfi_pkg::L_IDLE;
      sh_ff <= 8'h00;
      step_ff <= 3'h0;
      wid_ff <= 2'h0;
      rd_ff <= 1'b0;
      end_ff <= 1'b0;
      sck_ff <= 1'b0;
      ss_b_ff <= 1'b1;
      ack_tgl_ff <= 1'b0;
      rsp_ff <= 8'h00;
      req_seen_ff <= 1'b0;
      dout_ff <= 4'h0;
      doe_ff <= 4'h0;
    end else begin
      lst_ff <= nxt_lst;
      sh_ff <= nxt_sh;
      step_ff <= nxt_step;
      wid_ff <= nxt_wid;
      rd_ff <= nxt_rd;
      end_ff <= nxt_end;
      sck_ff <= nxt_sck;
      ss_b_ff <= nxt_ss_b;
      ack_tgl_ff <= nxt_ack_tgl;
      rsp_ff <= nxt_rsp;
      req_seen_ff <= nxt_req_seen;
      dout_ff <= nxt_dout;
      doe_ff <= nxt_doe;
    end
  end

  assign sck = sck_ff;
  assign ss_b = ss_b_ff;
  assign data_out = dout_ff;
  assign data_oe = doe_ff;
endmodule

/* sfi_pkg.sv */
package sfi_pkg;
  // control window offsets
  localparam logic [7:0] FIFO_CTRL_OFS = 8'h0C;
  localparam logic [7:0] INT_FL_OFS = 8'h14;
  localparam logic [7:0] INT_EN_OFS = 8'h18;
  // data window offsets
  localparam logic [7:0] TX_PORT_OFS = 8'h00;
  localparam logic [7:0] RX_PORT_OFS = 8'h04;

  // status flag / enable bit positions
  localparam int FLAG_W = 6;
  localparam int FL_RX_AF = 5;
  localparam int FL_TX_AE = 4;
  localparam int FL_RDONE = 3;
  localparam int FL_TRDY = 2;
  localparam int FL_RSTALL = 1;
  localparam int FL_TSTALL = 0;
  localparam logic [5:0] INT_FL_RST = 6'h10;
  localparam logic [5:0] INT_EN_RST = 6'h10;

  // fifo control fields
  localparam int TLVL_LSB = 0;
  localparam int TLVL_W = 4;
  localparam int TCNT_LSB = 8;
  localparam int RLVL_LSB = 16;
  localparam int RLVL_W = 5;
  localparam int RCNT_LSB = 24;
  localparam logic [3:0] TLVL_RST = 4'h0;
  localparam logic [4:0] RLVL_RST = 5'h00;

  // transaction word fields
  localparam int XW_DATA_LSB = 0;
  localparam int XW_WIDTH_LSB = 8;
  localparam int XW_READ_BIT = 10;
  localparam int XW_END_BIT = 11;

  localparam logic [1:0] SFI_W_SINGLE = 2'h0;
  localparam logic [1:0] SFI_W_DUAL = 2'h1;
  localparam logic [1:0] SFI_W_QUAD = 2'h2;

  typedef enum logic {C_IDLE = 1'h0, C_WAIT = 1'h1} sfi_core_st_t;
  typedef enum logic [1:0] {L_IDLE = 2'h0, L_SHIFT = 2'h1, L_DONE = 2'h3} sfi_link_st_t;
endpackage

/* sfi_flash_model.sv */
`timescale 1ns/1ps
module sfi_flash_model (
  input wire logic sck,
  input wire logic ss_b,
  input wire logic [1:0] wid,
  input wire logic [7:0] reply,
  input wire logic [3:0] dq_in,
  output logic [3:0] dq,
  output logic [7:0] got
);
  logic [7:0] sh;
  int step;
  int nb;
  assign nb = (wid == 2'h2) ? 4 : (wid == 2'h1) ? 2 : 1;
  // unused lines carry the inverse of the active bit, never a stale copy
  function automatic logic [3:0] lines(input logic [7:0] s);
    case (wid)
      2'h1: lines = {~s[7], ~s[6], s[7:6]};
      2'h2: lines = s[7:4];
      default: lines = {~s[7], ~s[7], s[7], ~s[7]};
    endcase
  endfunction
  initial begin
    dq = 4'h0;
    got = 8'h00;
    sh = 8'h00;
    step = 0;
  end
  always @(negedge ss_b) begin
    sh = reply;
    step = 0;
    dq = lines(reply);
  end
  // a released line does not keep showing the last level
  always @(posedge ss_b) dq = ~dq;
  always @(posedge sck) begin
    if (!ss_b) begin
      case (wid)
        2'h1: got = {got[5:0], dq_in[1:0]};
        2'h2: got = {got[3:0], dq_in};
        default: got = {got[6:0], dq_in[0]};
      endcase
    end
  end
  always @(negedge sck) begin
    if (!ss_b) begin
      step = step + 1;
      if (step * nb >= 8) begin
        sh = reply;
        step = 0;
      end else begin
        sh = sh << nb;
      end
      dq = lines(sh);
    end
  end
endmodule

/* sfi_ctrl_bench.sv */
`timescale 1ns/1ps
module sfi_ctrl_bench;
  localparam logic [7:0] FL = sfi_pkg::INT_FL_OFS;
  localparam logic [7:0] EN = sfi_pkg::INT_EN_OFS;
  localparam logic [7:0] CT = sfi_pkg::FIFO_CTRL_OFS;
  logic core_clk, link_clk, rst_b, csel, fsel, pen, pwr, ctl_pready, fifo_pready, irq, sck, ss_b;
  logic [7:0] pad, reply, got;
  logic [31:0] pwd, ctl_prdata, fifo_prdata, rd;
  logic [3:0] data_out, data_oe, data_in, dq;
  logic [1:0] wid;
  logic [7:0] rep [3] = '{8'hC3, 8'h5A, 8'h81};
  int fail_count, checks_done, cycles;

  sfi_ctrl i_dut (.core_clk(core_clk), .rst_b(rst_b), .link_clk(link_clk), .ctl_psel(csel),
    .ctl_penable(pen), .ctl_pwrite(pwr), .ctl_paddr(pad), .ctl_pwdata(pwd),
    .ctl_prdata(ctl_prdata), .ctl_pready(ctl_pready), .fifo_psel(fsel), .fifo_penable(pen),
    .fifo_pwrite(pwr), .fifo_paddr(pad), .fifo_pwdata(pwd), .fifo_prdata(fifo_prdata),
    .fifo_pready(fifo_pready), .irq(irq), .sck(sck), .ss_b(ss_b), .data_out(data_out),
    .data_oe(data_oe), .data_in(data_in));
  sfi_flash_model i_flash (.sck(sck), .ss_b(ss_b), .wid(wid), .reply(reply), .dq_in(data_in),
    .dq(dq), .got(got));
  assign data_in = (data_oe & data_out) | (~data_oe & dq);

  initial begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    link_clk = 1'h0;
    #3.7;
    forever #6 link_clk = ~link_clk;
  end
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 12000) begin
      fail_count = fail_count + 1;
      close_out();
    end
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // setup cycle, then access held until ready is sampled high or 8 negedge samples pass
  task automatic bus(input logic f, input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    csel <= ~f;
    fsel <= f;
    pen <= 1'h0;
    pwr <= w;
    pad <= a;
    pwd <= d;
    @(posedge core_clk);
    pen <= 1'h1;
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while ((f ? fifo_pready : ctl_pready) !== 1'h1 && n < 8);
    rd = f ? fifo_prdata : ctl_prdata;
    @(posedge core_clk);
    csel <= 1'h0;
    fsel <= 1'h0;
    pen <= 1'h0;
  endtask
  task automatic cw(input logic [7:0] a, input logic [31:0] d);
    bus(1'h0, 1'h1, a, d);
  endtask
  task automatic cr(input logic [7:0] a);
    bus(1'h0, 1'h0, a, 32'h0000_0000);
  endtask
  task automatic push(input logic [31:0] d);
    bus(1'h1, 1'h1, sfi_pkg::TX_PORT_OFS, d);
  endtask
  task automatic pop;
    bus(1'h1, 1'h0, sfi_pkg::RX_PORT_OFS, 32'h0000_0000);
  endtask
  task automatic wait_ss(input logic lvl);
    int n;
    n = 0;
    while (ss_b !== lvl && n < 300) begin
      @(posedge core_clk);
      n++;
    end
    chk(32'(n < 300), 32'h0000_0001);
    repeat (8) @(posedge core_clk);
  endtask
  function automatic logic [31:0] mk(input logic [1:0] w, input logic r, input logic e,
      input logic [7:0] b);
    mk = 32'h0000_0000;
    mk[sfi_pkg::XW_DATA_LSB +: 8] = b;
    mk[sfi_pkg::XW_WIDTH_LSB +: 2] = w;
    mk[sfi_pkg::XW_READ_BIT] = r;
    mk[sfi_pkg::XW_END_BIT] = e;
  endfunction

  task automatic t_reset;
    cr(EN);
    chk(rd, 32'h0000_0010);
    cr(FL);
    chk(rd, 32'h0000_0014);
    cr(CT);
    chk(rd, 32'h0000_0000);
    cr(8'h20);
    chk(rd, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0001);
  endtask
  task automatic t_mask;
    for (int i = 0; i < sfi_pkg::FLAG_W; i++) begin
      cw(EN, 32'h0000_0001 << i);
      repeat (3) @(posedge core_clk);
      chk({31'h0, irq}, {31'h0, (i == 2 || i == 4)});
    end
    cr(EN);
    chk(rd, 32'h0000_0020);
    cw(EN, 32'h0000_0000);
  endtask
  task automatic t_width;
    cw(CT, 32'h001F_0000);
    for (int w = 0; w < 3; w++) begin
      wid <= w[1:0];
      reply <= rep[w];
      cw(FL, 32'h0000_003F);
      push(mk(w[1:0], 1'h1, 1'h1, 8'hA6));
      wait_ss(1'h0);
      wait_ss(1'h1);
      if (w == 0) chk({24'h0, got}, 32'h0000_00A6);
      cr(FL);
      chk(rd & 32'h0000_002B, 32'h0000_0009);
      pop();
      chk(rd, {24'h0, rep[w]});
      pop();
      chk(rd, 32'h0000_0000);
      cw(FL, 32'h0000_0000);
      cr(FL);
      chk(rd & 32'h0000_0008, 32'h0000_0008);
      cw(FL, 32'h0000_0008);
      cr(FL);
      chk(rd & 32'h0000_0008, 32'h0000_0000);
    end
    wid <= 2'h2;
    push(mk(2'h2, 1'h0, 1'h1, 8'h96));
    wait_ss(1'h0);
    wait_ss(1'h1);
    chk({24'h0, got}, 32'h0000_0096);
    pop();
    chk(rd, 32'h0000_0000);
  endtask
  // results fill while the select stays active, then the transaction side refuses
  task automatic t_fill;
    wid <= 2'h0;
    reply <= 8'h5A;
    for (int i = 0; i < 34; i++) begin
      push(mk(2'h0, 1'h1, 1'h0, 8'(i)));
      repeat (40) @(posedge core_clk);
    end
    cr(CT);
    chk(rd & 32'h3F00_1F00, 32'h2000_0200);
    cw(FL, 32'h0000_003F);
    cr(FL);
    chk(rd, 32'h0000_0032);
    for (int i = 0; i < 15; i++) push(mk(2'h0, 1'h1, 1'h0, 8'h00));
    cr(CT);
    chk(rd & 32'h0000_1F00, 32'h0000_1000);
    cw(FL, 32'h0000_0010);
    cr(FL);
    chk(rd & 32'h0000_0010, 32'h0000_0000);
    pop();
    chk(rd, 32'h0000_005A);
  endtask

  initial begin
    rst_b = 1'h0;
    csel = 1'h0;
    fsel = 1'h0;
    pen = 1'h0;
    pwr = 1'h0;
    pad = 8'h00;
    pwd = 32'h0000_0000;
    wid = 2'h0;
    reply = 8'h00;
    repeat (12) @(posedge core_clk);
    chk({31'h0, irq}, 32'h0000_0000);
    rst_b <= 1'h1;
    repeat (2) @(posedge core_clk);
    t_reset();
    t_mask();
    t_width();
    t_fill();
    close_out();
  end
endmodule
